// file: verilog/timer16_cc_pkg.sv
// Constants and state type for the 16-bit timer compare, capture and interrupt block
package timer16_cc_pkg;

  // Register word offsets (byte address = offset * 4)
  localparam logic [5:0] CMP_A_LO_IDX  = 6'h00;
  localparam logic [5:0] CMP_A_HI_IDX  = 6'h01;
  localparam logic [5:0] CMP_B_LO_IDX  = 6'h02;
  localparam logic [5:0] CMP_B_HI_IDX  = 6'h03;
  localparam logic [5:0] CAP_LO_IDX    = 6'h04;
  localparam logic [5:0] CAP_HI_IDX    = 6'h05;
  localparam logic [5:0] IEN_IDX       = 6'h06;
  localparam logic [5:0] FLAGS_IDX     = 6'h07;
  localparam logic [5:0] CTRL_IDX      = 6'h08;

  // Enable and flag bit positions
  localparam int CAP_BIT = 5;
  localparam int CMPA_BIT = 4;
  localparam int CMPB_BIT = 3;
  localparam int OVF_BIT = 2;
  localparam int RSVD_BIT = 1;
  localparam logic [7:0] IEN_WMASK  = 8'hFD;
  localparam logic [7:0] FLAG_MASK  = 8'h3C;

  // Control register field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_EDGE_BIT = 4;
  localparam int CTRL_SRC_BIT = 5;
  localparam int CTRL_FRCA_BIT = 6;
  localparam int CTRL_FRCB_BIT = 7;

  // Reset values and fixed count limits
  localparam logic [15:0] CMP_RESET   = 16'h0000;
  localparam logic [15:0] CAP_RESET   = 16'h0000;
  localparam logic [7:0]  BYTE_RESET  = 8'h00;
  localparam logic [31:0] WORD_RESET  = 32'h0000_0000;
  localparam logic [15:0] CNT_MAX     = 16'hFFFF;
  localparam logic [15:0] CNT_BOTTOM  = 16'h0000;
  localparam logic [15:0] TOP_8BIT    = 16'h00FF;
  localparam logic [15:0] TOP_9BIT    = 16'h01FF;
  localparam logic [15:0] TOP_10BIT   = 16'h03FF;

  // Counter behaviour classes derived from the waveform mode
  typedef enum logic [1:0] {
    CLS_NONPWM = 2'b00,
    CLS_FAST   = 2'b01,
    CLS_PHASE  = 2'b10,
    CLS_NONE   = 2'b11
  } mode_class_t;

  // Whole state of the block, registered as one word
  typedef struct packed {
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] cap;
    logic [7:0]  temp;
    logic [7:0]  snap_hi;
    logic [7:0]  ien;
    logic [7:0]  flags;
    logic [3:0]  wmode;
    logic        edge_sel;
    logic        cap_src;
    logic        cap_s1;
    logic        cap_s2;
    logic        ac_s1;
    logic        ac_s2;
    logic        trig_prev;
    logic        match_a_q;
    logic        match_b_q;
    logic        block_pend;
    logic        cmp_a_evt;
    logic        cmp_b_evt;
    logic        cap_top;
    logic        irq;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } timer_state_t;

endpackage

// file: verilog/timer16_compare_capture_irq.sv
// Compare, capture and interrupt flag logic of a 16-bit timer, APB register slave
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps

// Overview of operation
// - Both compare registers are compared with the counter on each timer tick not blocked by a counter write; a match drives that channel's event output.
// - A write to a compare high byte goes to the shared byte latch and both bytes load together on the low-byte write.
// - Each selected edge on the capture pin, or on the comparator input when chosen, copies the counter into the capture register.
// - Reading the capture low byte places its matching high byte in the shared latch, which the following high-byte read returns.
// - In the modes that pick it, the capture register is the counter's upper limit and is offered as such.
// - The interrupt is raised when a flag, its enable bit (capture 5, compare A 4, compare B 3, overflow 2) and the global enable are all set.
// - A capture event sets the capture flag at bit 5 of the flag register.
// - When the capture register is the upper limit, the capture flag is set when the counter reaches that limit.
// - Executing an interrupt vector clears the matching flag.
// - Writing a one to a flag bit clears it and writing zero leaves it alone.
// - The compare A flag at bit 4 sets in the timer cycle after the counter equals compare A.
// - The compare B flag at bit 3 sets in the timer cycle after the counter equals compare B.
// - In non-PWM modes a force strobe acts on the channel output like a match but never sets the match flag.
// - Overflow flag bit 2 sets on overflow in normal and clear-on-match modes, and at the mode's own point otherwise.
// - While the capture register is the upper limit the capture input is disconnected.
// - The edge select bit picks falling edges at zero and rising edges at one.
module timer16_compare_capture_irq (
  input  wire logic        pclk,              // APB and timer clock
  input  wire logic        presetn,           // Asynchronous reset, active low
  input  wire logic        psel,              // APB select
  input  wire logic        penable,           // APB access phase
  input  wire logic        pwrite,            // APB write
  input  wire logic [7:0]  paddr,             // APB byte address
  input  wire logic [31:0] pwdata,            // APB write data
  output logic      [31:0] prdata,            // APB read data
  output logic             pready,            // APB ready
  output logic             pslverr,           // APB error, unmapped address
  input  wire logic [15:0] counter_value,     // Counter value, same clock
  input  wire logic        timer_tick,        // Timer clock enable pulse
  input  wire logic        counter_write,     // CPU wrote the counter
  input  wire logic        capture_input_pin, // Capture pin, asynchronous
  input  wire logic        comparator_out,    // Analog comparator, asynchronous
  input  wire logic        global_irq_enable, // CPU global interrupt enable
  input  wire logic [3:0]  vector_ack,        // Vector executed: cap, A, B, ovf
  output logic             irq,               // Interrupt request level
  output logic             compare_a_event,   // Channel A match or force pulse
  output logic             compare_b_event,   // Channel B match or force pulse
  output logic             capture_top_select,// Capture register is the limit
  output logic      [15:0] capture_value      // Capture register contents
);

  timer16_cc_pkg::timer_state_t s;
  timer16_cc_pkg::timer_state_t n;

  logic        setup;
  logic        wr_done;
  logic        rd_done;
  logic [5:0]  idx;
  logic        mapped;
  logic [7:0]  rd_mux;
  logic        trig;
  logic        edge_hit;
  logic        cap_evt;
  logic        cap_top_hit;
  logic        ovf_evt;
  logic        nonpwm;
  logic        force_a;
  logic        force_b;
  logic [15:0] top_val;
  logic [7:0]  clr_mask;
  logic [7:0]  set_mask;
  timer16_cc_pkg::mode_class_t cls;

  // Mode classes follow the waveform mode table
  function automatic timer16_cc_pkg::mode_class_t class_of(input logic [3:0] m);
    unique case (m)
      4'h0, 4'h4, 4'hC:
        class_of = timer16_cc_pkg::CLS_NONPWM;
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF:
        class_of = timer16_cc_pkg::CLS_FAST;
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB:
        class_of = timer16_cc_pkg::CLS_PHASE;
      default:
        class_of = timer16_cc_pkg::CLS_NONE;
    endcase
  endfunction

  function automatic logic cap_is_top(input logic [3:0] m);
    cap_is_top = (m == 4'h8) || (m == 4'hA) || (m == 4'hC) || (m == 4'hE);
  endfunction

  assign setup   = psel & ~penable;
  assign wr_done = psel & penable & s.pready & pwrite;
  assign rd_done = psel & penable & s.pready & ~pwrite;
  assign idx     = paddr[7:2];
  assign cls     = class_of(s.wmode);
  assign nonpwm  = (cls == timer16_cc_pkg::CLS_NONPWM);

  // Upper count limit per mode; capture register where selected
  always_comb
  begin
    unique case (s.wmode)
      4'h1, 4'h5:
        top_val = timer16_cc_pkg::TOP_8BIT;
      4'h2, 4'h6:
        top_val = timer16_cc_pkg::TOP_9BIT;
      4'h3, 4'h7:
        top_val = timer16_cc_pkg::TOP_10BIT;
      4'h4, 4'h9, 4'hB, 4'hF:
        top_val = s.cmp_a;
      4'h8, 4'hA, 4'hC, 4'hE:
        top_val = s.cap;
      default:
        top_val = timer16_cc_pkg::CNT_MAX;
    endcase
  end

  // Read mux; compare registers read directly, capture high comes from the latch
  always_comb
  begin
    mapped = 1'b1;
    rd_mux = timer16_cc_pkg::BYTE_RESET;
    unique case (idx)
      timer16_cc_pkg::CMP_A_LO_IDX: rd_mux = s.cmp_a[7:0];
      timer16_cc_pkg::CMP_A_HI_IDX: rd_mux = s.cmp_a[15:8];
      timer16_cc_pkg::CMP_B_LO_IDX: rd_mux = s.cmp_b[7:0];
      timer16_cc_pkg::CMP_B_HI_IDX: rd_mux = s.cmp_b[15:8];
      timer16_cc_pkg::CAP_LO_IDX:   rd_mux = s.cap[7:0];
      timer16_cc_pkg::CAP_HI_IDX:   rd_mux = s.temp;
      timer16_cc_pkg::IEN_IDX:      rd_mux = s.ien;
      timer16_cc_pkg::FLAGS_IDX:    rd_mux = s.flags;
      timer16_cc_pkg::CTRL_IDX:     rd_mux = {2'b00, s.cap_src, s.edge_sel, s.wmode};
      default:                      mapped = 1'b0;
    endcase
  end

  // Capture trigger path; only synchronised copies are looked at
  assign trig        = s.cap_src ? s.ac_s2 : s.cap_s2;
  assign edge_hit    = s.edge_sel ? (trig & ~s.trig_prev) : (~trig & s.trig_prev);
  assign cap_evt     = edge_hit & ~cap_is_top(s.wmode);
  assign cap_top_hit = cap_is_top(s.wmode) & timer_tick & (counter_value == s.cap);

  // Overflow point depends on the counting class
  always_comb
  begin
    unique case (cls)
      timer16_cc_pkg::CLS_NONPWM:
        ovf_evt = timer_tick & (counter_value == timer16_cc_pkg::CNT_MAX);
      timer16_cc_pkg::CLS_FAST:
        ovf_evt = timer_tick & (counter_value == top_val);
      timer16_cc_pkg::CLS_PHASE:
        ovf_evt = timer_tick & (counter_value == timer16_cc_pkg::CNT_BOTTOM);
      default:
        ovf_evt = 1'b0;
    endcase
  end

  // Force strobes only act in non-PWM modes
  assign force_a = wr_done & (idx == timer16_cc_pkg::CTRL_IDX) & nonpwm
                   & pwdata[timer16_cc_pkg::CTRL_FRCA_BIT];
  assign force_b = wr_done & (idx == timer16_cc_pkg::CTRL_IDX) & nonpwm
                   & pwdata[timer16_cc_pkg::CTRL_FRCB_BIT];

  // Flag clears: software write-one and vector execution
  always_comb
  begin
    clr_mask = timer16_cc_pkg::BYTE_RESET;
    if (wr_done && idx == timer16_cc_pkg::FLAGS_IDX)
    begin
      clr_mask = pwdata[7:0];
    end
    clr_mask[timer16_cc_pkg::CAP_BIT]  = clr_mask[timer16_cc_pkg::CAP_BIT] | vector_ack[3];
    clr_mask[timer16_cc_pkg::CMPA_BIT] = clr_mask[timer16_cc_pkg::CMPA_BIT] | vector_ack[2];
    clr_mask[timer16_cc_pkg::CMPB_BIT] = clr_mask[timer16_cc_pkg::CMPB_BIT] | vector_ack[1];
    clr_mask[timer16_cc_pkg::OVF_BIT]  = clr_mask[timer16_cc_pkg::OVF_BIT] | vector_ack[0];
  end

  // Flag sets; match flags use the registered match, so force never reaches them
  always_comb
  begin
    set_mask = timer16_cc_pkg::BYTE_RESET;
    set_mask[timer16_cc_pkg::CAP_BIT]  = cap_evt | cap_top_hit;
    set_mask[timer16_cc_pkg::CMPA_BIT] = s.match_a_q;
    set_mask[timer16_cc_pkg::CMPB_BIT] = s.match_b_q;
    set_mask[timer16_cc_pkg::OVF_BIT]  = ovf_evt;
  end

  always_comb
  begin
    n = s;

    // Two-stage synchronisers for the asynchronous inputs
    n.cap_s1    = capture_input_pin;
    n.cap_s2    = s.cap_s1;
    n.ac_s1     = comparator_out;
    n.ac_s2     = s.ac_s1;
    n.trig_prev = trig;

    // Register writes, taken on the completing APB edge
    if (wr_done)
    begin
      unique case (idx)
        timer16_cc_pkg::CMP_A_LO_IDX: n.cmp_a = {s.temp, pwdata[7:0]};
        timer16_cc_pkg::CMP_B_LO_IDX: n.cmp_b = {s.temp, pwdata[7:0]};
        timer16_cc_pkg::CAP_LO_IDX:   n.cap   = {s.temp, pwdata[7:0]};
        timer16_cc_pkg::CMP_A_HI_IDX,
        timer16_cc_pkg::CMP_B_HI_IDX,
        timer16_cc_pkg::CAP_HI_IDX:   n.temp  = pwdata[7:0];
        timer16_cc_pkg::IEN_IDX:      n.ien   = pwdata[7:0] & timer16_cc_pkg::IEN_WMASK;
        timer16_cc_pkg::CTRL_IDX:
        begin
          n.wmode    = pwdata[timer16_cc_pkg::CTRL_MODE_LSB +: 4];
          n.edge_sel = pwdata[timer16_cc_pkg::CTRL_EDGE_BIT];
          n.cap_src  = pwdata[timer16_cc_pkg::CTRL_SRC_BIT];
        end
        default:
        begin
        end
      endcase
    end

    // Low-byte read hands the snapshot high byte to the latch
    if (rd_done && idx == timer16_cc_pkg::CAP_LO_IDX)
    begin
      n.temp = s.snap_hi;
    end

    // A capture event wins over a CPU write in the same cycle
    if (cap_evt)
    begin
      n.cap = counter_value;
    end

    // Counter writes block the match on the next timer tick
    if (counter_write)
    begin
      n.block_pend = 1'b1;
    end
    else if (timer_tick)
    begin
      n.block_pend = 1'b0;
    end
    n.match_a_q = timer_tick & ~s.block_pend & (counter_value == s.cmp_a);
    n.match_b_q = timer_tick & ~s.block_pend & (counter_value == s.cmp_b);
    n.cmp_a_evt = s.match_a_q | force_a;
    n.cmp_b_evt = s.match_b_q | force_b;

    // Set wins over a clear in the same cycle
    n.flags   = ((s.flags & ~clr_mask) | set_mask) & timer16_cc_pkg::FLAG_MASK;
    n.irq     = global_irq_enable & |(n.flags & n.ien);
    n.cap_top = cap_is_top(n.wmode);

    // No wait state; ready and read data come from flip-flops loaded in the setup cycle
    n.pready  = setup;
    n.pslverr = setup & ~mapped;
    n.prdata  = setup ? {24'h00_0000, rd_mux} : timer16_cc_pkg::WORD_RESET;
    if (setup)
    begin
      n.snap_hi = s.cap[15:8];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= n;
    end
  end

  assign prdata             = s.prdata;
  assign pready             = s.pready;
  assign pslverr            = s.pslverr;
  assign irq                = s.irq;
  assign compare_a_event    = s.cmp_a_evt;
  assign compare_b_event    = s.cmp_b_evt;
  assign capture_top_select = s.cap_top;
  assign capture_value      = s.cap;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_cmpa_flag_timing: assert property (
    (timer_tick && !s.block_pend && counter_value == s.cmp_a
     && !(s.flags[timer16_cc_pkg::CMPA_BIT])) |=> ##1 s.flags[timer16_cc_pkg::CMPA_BIT])
    else $error("compare A flag not set one cycle after match");

  chk_cmpb_flag_timing: assert property (
    (timer_tick && !s.block_pend && counter_value == s.cmp_b) |=> ##1
     s.flags[timer16_cc_pkg::CMPB_BIT])
    else $error("compare B flag not set one cycle after match");

  chk_force_no_flag: assert property (
    $rose(s.flags[timer16_cc_pkg::CMPA_BIT]) |-> $past(s.match_a_q))
    else $error("compare A flag set without a real match");

  chk_irq_gating: assert property (
    s.irq == ($past(global_irq_enable) && (|(s.flags & s.ien))))
    else $error("interrupt level does not follow flags, enables and global enable");

  chk_reserved_zero: assert property (
    !s.ien[timer16_cc_pkg::RSVD_BIT] && !s.flags[timer16_cc_pkg::RSVD_BIT])
    else $error("reserved bit 1 reads non-zero");

  chk_capture_load: assert property (
    cap_evt |=> (s.cap == $past(counter_value)) && s.flags[timer16_cc_pkg::CAP_BIT])
    else $error("capture event did not load counter and set flag");

  chk_capture_blocked: assert property (
    cap_is_top(s.wmode) && !wr_done |=> $stable(s.cap))
    else $error("capture register changed while used as limit");

  chk_w1c_clear: assert property (
    (wr_done && idx == timer16_cc_pkg::FLAGS_IDX && pwdata[timer16_cc_pkg::OVF_BIT]
     && !ovf_evt) |=> !s.flags[timer16_cc_pkg::OVF_BIT])
    else $error("overflow flag not cleared by write of one");

  chk_vector_clear: assert property (
    (vector_ack[2] && !s.match_a_q) |=> !s.flags[timer16_cc_pkg::CMPA_BIT])
    else $error("compare A flag not cleared by vector execution");

  chk_hi_latch_read: assert property (
    (rd_done && idx == timer16_cc_pkg::CAP_LO_IDX && !wr_done) |=> s.temp == $past(s.snap_hi))
    else $error("capture high byte not latched on low read");

  chk_apb_answer: assert property (
    setup |=> s.pready ##1 !s.pready)
    else $error("ready not a single cycle after setup");

  chk_cap_top_flag: assert property (
    cap_top_hit |=> s.flags[timer16_cc_pkg::CAP_BIT])
    else $error("capture flag not set at the capture limit");

  chk_force_b_flag: assert property (
    $rose(s.flags[timer16_cc_pkg::CMPB_BIT]) |-> $past(s.match_b_q))
    else $error("compare B flag set without a real match");

  chk_cmpa_event: assert property (
    s.match_a_q |=> s.cmp_a_evt)
    else $error("compare A match gave no event pulse");

  chk_cmpb_event: assert property (
    s.match_b_q |=> s.cmp_b_evt)
    else $error("compare B match gave no event pulse");

  chk_match_blocked: assert property (
    (timer_tick && s.block_pend) |=> !s.match_a_q && !s.match_b_q)
    else $error("match seen on the tick after a counter write");

  chk_ovf_normal: assert property (
    (timer_tick && nonpwm && counter_value == timer16_cc_pkg::CNT_MAX)
    |=> s.flags[timer16_cc_pkg::OVF_BIT])
    else $error("overflow flag not set at the maximum count");

  chk_cap_vector: assert property (
    (vector_ack[3] && !cap_evt && !cap_top_hit) |=> !s.flags[timer16_cc_pkg::CAP_BIT])
    else $error("capture flag not cleared by vector execution");

  chk_hi_write_latch: assert property (
    (wr_done && (idx == timer16_cc_pkg::CMP_A_HI_IDX || idx == timer16_cc_pkg::CMP_B_HI_IDX))
    |=> s.temp == $past(pwdata[7:0]))
    else $error("high byte write not held in the shared latch");

  chk_prdata_idle: assert property (
    !s.pready |-> s.prdata == timer16_cc_pkg::WORD_RESET)
    else $error("read data not zero outside the ready cycle");

  chk_err_with_ready: assert property (
    s.pslverr |-> s.pready)
    else $error("error flagged outside the ready cycle");

  cov_capture_event: cover property (cap_evt ##[1:20] s.irq);
  cov_compare_a_irq: cover property (s.match_a_q ##1 s.flags[timer16_cc_pkg::CMPA_BIT]);
  cov_force_a: cover property (force_a ##1 s.cmp_a_evt);
  cov_cap_top_flag: cover property (cap_top_hit);
  cov_overflow: cover property (ovf_evt ##1 s.flags[timer16_cc_pkg::OVF_BIT]);

endmodule

// file: verif/cpu_bus_model.sv
// CPU side APB master model for the timer register slave
`timescale 1ns/1ps
module cpu_bus_model (
  input  wire logic        pclk,    // Bus clock
  input  wire logic [31:0] prdata,  // Read data
  input  wire logic        pready,  // Slave ready
  input  wire logic        pslverr, // Slave error
  output logic             psel,    // Select
  output logic             penable, // Access phase
  output logic             pwrite,  // Direction
  output logic      [7:0]  paddr,   // Byte address
  output logic      [31:0] pwdata   // Write data
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // Held until pready is seen; released lines show inverted junk, not the old value
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count assumed; only the bench watchdog ends a stuck wait
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule

// file: verif/tb.sv
// Self-checking bench of the timer compare, capture and interrupt block
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] A_LO = {timer16_cc_pkg::CMP_A_LO_IDX, 2'b00};
  localparam logic [7:0] A_HI = {timer16_cc_pkg::CMP_A_HI_IDX, 2'b00};
  localparam logic [7:0] B_LO = {timer16_cc_pkg::CMP_B_LO_IDX, 2'b00};
  localparam logic [7:0] B_HI = {timer16_cc_pkg::CMP_B_HI_IDX, 2'b00};
  localparam logic [7:0] C_LO = {timer16_cc_pkg::CAP_LO_IDX, 2'b00};
  localparam logic [7:0] C_HI = {timer16_cc_pkg::CAP_HI_IDX, 2'b00};
  localparam logic [7:0] IEN  = {timer16_cc_pkg::IEN_IDX, 2'b00};
  localparam logic [7:0] FLG  = {timer16_cc_pkg::FLAGS_IDX, 2'b00};
  localparam logic [7:0] CTL  = {timer16_cc_pkg::CTRL_IDX, 2'b00};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] counter_value, capture_value;
  logic        timer_tick, counter_write, capture_input_pin, comparator_out;
  logic        global_irq_enable, compare_a_event, compare_b_event, capture_top_select;
  logic [3:0]  vector_ack;
  int          err_total;
  int          samples_checked;

  timer16_compare_capture_irq dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .counter_value(counter_value),
    .timer_tick(timer_tick), .counter_write(counter_write),
    .capture_input_pin(capture_input_pin), .comparator_out(comparator_out),
    .global_irq_enable(global_irq_enable), .vector_ack(vector_ack), .irq(irq),
    .compare_a_event(compare_a_event), .compare_b_event(compare_b_event),
    .capture_top_select(capture_top_select), .capture_value(capture_value));
  cpu_bus_model cpu (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    logic        e;
    cpu.xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    cpu.xfer(1'b0, a, 32'h0000_0000, q, e);
    chk($sformatf("reg %h", a), q, exp);
    chk("reg err", e, 1'b0);
  endtask

  task automatic settle(int n);
    repeat (n) @(posedge pclk);
  endtask

  // One tick with the counter held, then the event one and two edges later
  task automatic tick_evt(logic [15:0] v, logic ch, logic exp);
    counter_value <= v;
    timer_tick    <= 1'b1;
    @(posedge pclk);
    timer_tick <= 1'b0;
    #1;
    chk("event early", ch ? compare_b_event : compare_a_event, 1'b0);
    @(posedge pclk);
    #1;
    chk("event", ch ? compare_b_event : compare_a_event, exp);
    @(posedge pclk);
  endtask

  task automatic t_regs;
    logic [31:0] q;
    logic        e;
    rd(IEN, 32'h0000_0000);
    rd(FLG, 32'h0000_0000);
    rd(A_LO, 32'h0000_0000);
    wr(IEN, 32'h0000_00FF);
    rd(IEN, 32'h0000_00FD);
    wr(FLG, 32'h0000_00FF);
    rd(FLG, 32'h0000_0000);
    cpu.xfer(1'b0, 8'h24, 32'h0000_0000, q, e);
    chk("unmapped err", e, 1'b1);
    chk("unmapped data", q, 32'h0000_0000);
    wr(IEN, 32'h0000_0000);
  endtask

  task automatic t_cmp;
    wr(A_HI, 32'h0000_001A);
    rd(A_HI, 32'h0000_0000);
    wr(A_LO, 32'h0000_002B);
    rd(A_HI, 32'h0000_001A);
    tick_evt(16'h1A2B, 1'b0, 1'b1);
    rd(FLG, 32'h0000_0010);
    wr(B_HI, 32'h0000_0000);
    wr(B_LO, 32'h0000_00C3);
    tick_evt(16'h00C3, 1'b1, 1'b1);
    rd(FLG, 32'h0000_0018);
  endtask

  task automatic t_irq;
    wr(FLG, 32'h0000_0000);
    rd(FLG, 32'h0000_0018);
    global_irq_enable <= 1'b1;
    wr(IEN, 32'h0000_0010);
    settle(2);
    chk("irq on", irq, 1'b1);
    global_irq_enable <= 1'b0;
    settle(2);
    chk("irq global off", irq, 1'b0);
    global_irq_enable <= 1'b1;
    wr(FLG, 32'h0000_0010);
    rd(FLG, 32'h0000_0008);
    settle(1);
    chk("irq cleared", irq, 1'b0);
    vector_ack <= 4'b0010;
    @(posedge pclk);
    vector_ack <= 4'b0000;
    rd(FLG, 32'h0000_0000);
  endtask

  task automatic t_ovf;
    wr(CTL, 32'h0000_0000);
    tick_evt(16'hFFFF, 1'b0, 1'b0);
    rd(FLG, 32'h0000_0004);
    vector_ack <= 4'b0001;
    @(posedge pclk);
    vector_ack <= 4'b0000;
    rd(FLG, 32'h0000_0000);
  endtask

  task automatic t_force(logic ch);
    logic got;
    got = 1'b0;
    wr(CTL, ch ? 32'h0000_0080 : 32'h0000_0040);
    repeat (6)
    begin
      #1;
      if ((ch ? compare_b_event : compare_a_event) === 1'b1) got = 1'b1;
      @(posedge pclk);
    end
    chk("forced event", got, 1'b1);
    rd(FLG, 32'h0000_0000);
  endtask

  task automatic t_cap;
    counter_value <= 16'h1234;
    wr(CTL, 32'h0000_0010);
    capture_input_pin <= 1'b1;
    settle(8);
    chk("capture rise", capture_value, 16'h1234);
    rd(FLG, 32'h0000_0020);
    counter_value     <= 16'h5678;
    capture_input_pin <= 1'b0;
    settle(8);
    chk("capture fall ignored", capture_value, 16'h1234);
    rd(C_LO, 32'h0000_0034);
    capture_input_pin <= 1'b1;
    settle(8);
    rd(C_HI, 32'h0000_0012);
    rd(C_LO, 32'h0000_0078);
    rd(C_HI, 32'h0000_0056);
  endtask

  // Capture register as limit: pin cut off, flag from reaching the limit
  task automatic t_top;
    wr(CTL, 32'h0000_001C);
    settle(2);
    chk("top select", capture_top_select, 1'b1);
    wr(FLG, 32'h0000_003C);
    capture_input_pin <= 1'b0;
    settle(8);
    counter_value     <= 16'h4444;
    capture_input_pin <= 1'b1;
    settle(8);
    chk("capture blocked", capture_value, 16'h5678);
    rd(FLG, 32'h0000_0000);
    tick_evt(16'h5678, 1'b0, 1'b0);
    rd(FLG, 32'h0000_0020);
  endtask

  // Comparator source, capture interrupt, match blocking, PWM overflow points
  task automatic t_more;
    wr(FLG, 32'h0000_003C);
    wr(CTL, 32'h0000_0030);
    wr(IEN, 32'h0000_0020);
    counter_value  <= 16'h0ABC;
    comparator_out <= 1'b1;
    settle(8);
    chk("comparator capture", capture_value, 16'h0ABC);
    chk("capture irq", irq, 1'b1);
    vector_ack <= 4'b1000;
    @(posedge pclk);
    vector_ack <= 4'b0000;
    rd(FLG, 32'h0000_0000);
    chk("capture irq off", irq, 1'b0);
    counter_write <= 1'b1;
    @(posedge pclk);
    counter_write <= 1'b0;
    tick_evt(16'h1A2B, 1'b0, 1'b0);
    rd(FLG, 32'h0000_0000);
    tick_evt(16'h1A2B, 1'b0, 1'b1);
    vector_ack <= 4'b0100;
    @(posedge pclk);
    vector_ack <= 4'b0000;
    rd(FLG, 32'h0000_0000);
    wr(CTL, 32'h0000_0005);
    tick_evt(16'h00FF, 1'b0, 1'b0);
    rd(FLG, 32'h0000_0004);
    wr(CTL, 32'h0000_0001);
    wr(FLG, 32'h0000_0004);
    tick_evt(16'h0000, 1'b0, 1'b0);
    rd(FLG, 32'h0000_0004);
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial
  begin
    #100000;
    err_total++;
    stop_test();
  end

  initial
  begin
    err_total         = 0;
    samples_checked   = 0;
    presetn           = 1'b0;
    counter_value     = 16'h0000;
    timer_tick        = 1'b0;
    counter_write     = 1'b0;
    capture_input_pin = 1'b0;
    comparator_out    = 1'b0;
    global_irq_enable = 1'b0;
    vector_ack        = 4'b0000;
    settle(4);
    presetn <= 1'b1;
    t_regs();
    t_cmp();
    t_irq();
    t_ovf();
    t_force(1'b0);
    t_force(1'b1);
    t_cap();
    t_top();
    t_more();
    stop_test();
  end
endmodule
